// file: core_status_params.svh
`ifndef CORE_STATUS_PARAMS_SVH
`define CORE_STATUS_PARAMS_SVH

// ----------------------------------------
// register offset and bit positions
// ----------------------------------------
`define STATUS_OFFSET          8'h03
`define BIT_INDIRECT_BANK_HIGH 7
`define BIT_BANK_SELECT_HIGH   6
`define BIT_BANK_SELECT_LOW    5
`define BIT_WATCHDOG_TIMEOUT   4
`define BIT_SLEEP_ENTRY        3
`define BIT_ZERO               2
`define BIT_NIBBLE_CARRY       1
`define BIT_CARRY              0

// ----------------------------------------
// reset value, writable mask, clear value and bank base
// ----------------------------------------
`define STATUS_RESET           8'h18
`define STATUS_WRITABLE_MASK   8'hE7
`define STATUS_CLEAR_VALUE     8'h04
`define BANK1_BASE             8'h80

`endif

// file: core_status_pkg.sv
package core_status_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_MOVE,
        OP_CLEAR,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_COMPLEMENT,
        OP_INCREMENT,
        OP_DECREMENT,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT,
        OP_SWAP,
        OP_BIT_CLEAR,
        OP_BIT_SET
    } alu_op_t;

endpackage

// file: status_alu.sv
`timescale 1ns/1ps
`include "core_status_params.svh"

module status_alu #(
    parameter int WIDTH = 8
) (
    input  wire logic                  [3:0]       op,
    input  wire logic                  [WIDTH-1:0] operand_a,
    input  wire logic                  [WIDTH-1:0] operand_b,
    input  wire logic                  [2:0]       bit_index,
    input  wire logic                              carry_in,
    output logic                       [WIDTH-1:0] result,
    output logic                                   zero_out,
    output logic                                   nibble_carry_out,
    output logic                                   carry_out,
    output logic                                   affects_zero,
    output logic                                   affects_carry
);

    // ----------------------------------------
    // adder shared by add and subtract
    // ----------------------------------------
    function automatic logic [WIDTH:0] add_full(input logic [WIDTH-1:0] a,
                                                 input logic [WIDTH-1:0] b,
                                                 input logic             cin);
        add_full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    endfunction

    function automatic logic [4:0] add_nibble(input logic [3:0] a,
                                               input logic [3:0] b,
                                               input logic       cin);
        add_nibble = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction

    logic [WIDTH-1:0] addend_b;
    logic             addend_cin;
    logic [WIDTH:0]   sum_full;
    logic [4:0]       sum_nibble;
    core_status_pkg::alu_op_t op_e;

    assign op_e = core_status_pkg::alu_op_t'(op);

    // subtract adds the two's complement: inverted b plus one
    always_comb begin
        addend_b   = operand_b;
        addend_cin = 1'b0;
        if (op_e == core_status_pkg::OP_SUB) begin
            addend_b   = ~operand_b;
            addend_cin = 1'b1;
        end
    end

    // carry out of add of the complement is the inverted borrow
    assign sum_full   = add_full(operand_a, addend_b, addend_cin);
    assign sum_nibble = add_nibble(operand_a[3:0], addend_b[3:0], addend_cin);

    always_comb begin
        result           = operand_a;
        nibble_carry_out = 1'b0;
        carry_out        = carry_in;
        affects_zero     = 1'b0;
        affects_carry    = 1'b0;
        case (op_e)
            core_status_pkg::OP_MOVE: begin
                result       = operand_a;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_CLEAR: begin
                result       = '0;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_ADD, core_status_pkg::OP_SUB: begin
                result           = sum_full[WIDTH-1:0];
                nibble_carry_out = sum_nibble[4];
                carry_out        = sum_full[WIDTH];
                affects_zero     = 1'b1;
                affects_carry    = 1'b1;
            end
            core_status_pkg::OP_AND: begin
                result       = operand_a & operand_b;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_OR: begin
                result       = operand_a | operand_b;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_XOR: begin
                result       = operand_a ^ operand_b;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_COMPLEMENT: begin
                result       = ~operand_a;
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_INCREMENT: begin
                result       = WIDTH'(operand_a + 1'b1);
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_DECREMENT: begin
                result       = WIDTH'(operand_a - 1'b1);
                affects_zero = 1'b1;
            end
            core_status_pkg::OP_ROTATE_LEFT: begin
                result    = {operand_a[WIDTH-2:0], carry_in};
                carry_out = operand_a[WIDTH-1];
            end
            core_status_pkg::OP_ROTATE_RIGHT: begin
                result    = {carry_in, operand_a[WIDTH-1:1]};
                carry_out = operand_a[0];
            end
            core_status_pkg::OP_SWAP: begin
                result = {operand_a[3:0], operand_a[WIDTH-1:4]};
            end
            core_status_pkg::OP_BIT_CLEAR: begin
                result            = operand_a;
                result[bit_index] = 1'b0;
            end
            core_status_pkg::OP_BIT_SET: begin
                result            = operand_a;
                result[bit_index] = 1'b1;
            end
            default: begin
                result = operand_a;
            end
        endcase
    end

    assign zero_out = (result == '0);

endmodule

// file: core_status_flags.sv
`timescale 1ns/1ps
`include "core_status_params.svh"

module core_status_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // instruction execution port
    input  wire logic                  exec_valid,
    input  wire logic [3:0]            exec_op,
    input  wire logic [WIDTH-1:0]      exec_operand_a,
    input  wire logic [WIDTH-1:0]      exec_operand_b,
    input  wire logic [2:0]            exec_bit_index,
    input  wire logic [7:0]            exec_dest_addr,
    input  wire logic                  exec_dest_file,
    input  wire logic [6:0]            direct_addr,
    // events from the core
    input  wire logic                  watchdog_clear_instruction,
    input  wire logic                  sleep_instruction,
    input  wire logic                  watchdog_timeout,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [7:0]            reg_rdata,
    // results
    output logic      [WIDTH-1:0]      exec_result,
    output logic                       exec_result_valid,
    output logic      [7:0]            bank_address,
    output logic      [7:0]            status_value
);

    // ----------------------------------------
    // alu
    // ----------------------------------------
    logic [WIDTH-1:0] alu_result;
    logic             alu_zero;
    logic             alu_nibble_carry;
    logic             alu_carry;
    logic             alu_affects_zero;
    logic             alu_affects_carry;

    logic             indirect_bank_high_q;
    logic             bank_select_high_q;
    logic             bank_select_low_q;
    logic             watchdog_timeout_flag_q;
    logic             sleep_entry_flag_q;
    logic             zero_flag_q;
    logic             nibble_carry_flag_q;
    logic             carry_flag_q;

    status_alu #(
        .WIDTH (WIDTH)
    ) u_alu (
        .op               (exec_op),
        .operand_a        (exec_operand_a),
        .operand_b        (exec_operand_b),
        .bit_index        (exec_bit_index),
        .carry_in         (carry_flag_q),
        .result           (alu_result),
        .zero_out         (alu_zero),
        .nibble_carry_out (alu_nibble_carry),
        .carry_out        (alu_carry),
        .affects_zero     (alu_affects_zero),
        .affects_carry    (alu_affects_carry)
    );

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    logic       exec_hits_status;
    logic       bus_hits_status;
    logic       status_write;
    logic [7:0] status_wdata;
    logic       flags_from_logic;
    logic       clear_to_status;
    logic       exec_clear;
    logic       exec_rot;

    assign exec_clear = exec_op == 4'(core_status_pkg::OP_CLEAR);
    assign exec_rot   = (exec_op == 4'(core_status_pkg::OP_ROTATE_LEFT))
                     || (exec_op == 4'(core_status_pkg::OP_ROTATE_RIGHT));

    // status treated as any other file destination
    assign exec_hits_status = exec_valid && exec_dest_file
                           && (exec_dest_addr == `STATUS_OFFSET);
    assign bus_hits_status  = reg_write && (reg_addr == `STATUS_OFFSET);
    assign status_write     = exec_hits_status || bus_hits_status;
    assign status_wdata     = exec_hits_status ? 8'(alu_result) : reg_wdata;
    // all three flag bits lose the data write when the instruction drives any flag itself
    assign flags_from_logic = exec_hits_status
                           && (alu_affects_zero || alu_affects_carry || exec_rot);
    assign clear_to_status  = exec_hits_status && exec_clear;

    // ----------------------------------------
    // bank select and reserved bits
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            indirect_bank_high_q <= 1'b0;
            bank_select_high_q   <= 1'b0;
            bank_select_low_q    <= 1'b0;
        end else if (clear_to_status) begin
            indirect_bank_high_q <= 1'b0;
            bank_select_high_q   <= 1'b0;
            bank_select_low_q    <= 1'b0;
        end else if (status_write) begin
            // top bits are stored as written; software keeps them zero
            indirect_bank_high_q <= status_wdata[`BIT_INDIRECT_BANK_HIGH];
            bank_select_high_q   <= status_wdata[`BIT_BANK_SELECT_HIGH];
            bank_select_low_q    <= status_wdata[`BIT_BANK_SELECT_LOW];
        end
    end

    // ----------------------------------------
    // reset cause flags
    // ----------------------------------------
    // writes never reach these bits; a timeout in the same cycle as a
    // clear wins so that the event is not lost
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            watchdog_timeout_flag_q <= 1'b1;
        end else if (watchdog_timeout) begin
            watchdog_timeout_flag_q <= 1'b0;
        end else if (watchdog_clear_instruction || sleep_instruction) begin
            watchdog_timeout_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_entry_flag_q <= 1'b1;
        end else if (sleep_instruction) begin
            sleep_entry_flag_q <= 1'b0;
        end else if (watchdog_clear_instruction) begin
            sleep_entry_flag_q <= 1'b1;
        end
    end
    // no write path above keeps both flags read-only

    // ----------------------------------------
    // arithmetic flags
    // ----------------------------------------
    // reset value is undefined in the part; zero is chosen for determinism
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zero_flag_q <= 1'b0;
        end else if (exec_valid && alu_affects_zero) begin
            zero_flag_q <= alu_zero;
        end else if (status_write && !flags_from_logic) begin
            zero_flag_q <= status_wdata[`BIT_ZERO];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            nibble_carry_flag_q <= 1'b0;
        end else if (exec_valid && alu_affects_carry) begin
            nibble_carry_flag_q <= alu_nibble_carry;
        end else if (status_write && !flags_from_logic) begin
            nibble_carry_flag_q <= status_wdata[`BIT_NIBBLE_CARRY];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            carry_flag_q <= 1'b0;
        end else if (exec_valid && (alu_affects_carry || exec_rot)) begin
            carry_flag_q <= alu_carry;
        end else if (status_write && !flags_from_logic) begin
            carry_flag_q <= status_wdata[`BIT_CARRY];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        status_value = 8'h00;
        status_value[`BIT_INDIRECT_BANK_HIGH] = indirect_bank_high_q;
        status_value[`BIT_BANK_SELECT_HIGH]   = bank_select_high_q;
        status_value[`BIT_BANK_SELECT_LOW]    = bank_select_low_q;
        status_value[`BIT_WATCHDOG_TIMEOUT]   = watchdog_timeout_flag_q;
        status_value[`BIT_SLEEP_ENTRY]        = sleep_entry_flag_q;
        status_value[`BIT_ZERO]               = zero_flag_q;
        status_value[`BIT_NIBBLE_CARRY]       = nibble_carry_flag_q;
        status_value[`BIT_CARRY]              = carry_flag_q;
    end

    // the bank bit only extends direct addresses; 0 gives 00h-7Fh
    assign bank_address = {bank_select_low_q, direct_addr};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && reg_addr == `STATUS_OFFSET) begin
            reg_rdata <= status_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exec_result       <= '0;
            exec_result_valid <= 1'b0;
        end else begin
            exec_result       <= alu_result;
            exec_result_valid <= exec_valid;
        end
    end

endmodule

// file: core_status_flags_assertions.sv
`timescale 1ns/1ps
module core_status_flags_checker #(
    parameter int WIDTH = 8
) (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic             exec_valid,
    input wire logic [3:0]       exec_op,
    input wire logic [WIDTH-1:0] exec_operand_a,
    input wire logic [WIDTH-1:0] exec_operand_b,
    input wire logic [7:0]       exec_dest_addr,
    input wire logic             exec_dest_file,
    input wire logic [6:0]       direct_addr,
    input wire logic             watchdog_clear_instruction,
    input wire logic             sleep_instruction,
    input wire logic             watchdog_timeout,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [7:0]       reg_rdata,
    input wire logic [WIDTH-1:0] exec_result,
    input wire logic             exec_result_valid,
    input wire logic [7:0]       bank_address,
    input wire logic [7:0]       status_value
);
    logic a_top_q;
    logic any_event;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    assign any_event = watchdog_clear_instruction | sleep_instruction | watchdog_timeout;

    // helper flop: the bit a left rotate pushes out of the source
    always_ff @(posedge ref_clk) begin
        a_top_q <= exec_operand_a[WIDTH-1];
    end

    chk_reset_value: assert property (
        $rose(rst_n) |-> status_value == 8'h18) else $error("status wrong after reset");
    chk_bank_map: assert property (
        bank_address == {status_value[5], direct_addr}) else $error("bank address wrong");
    chk_timeout_clear: assert property (
        watchdog_timeout |=> !status_value[4]) else $error("timeout flag not cleared");
    chk_sleep_flags: assert property (
        sleep_instruction && !watchdog_timeout |=> status_value[4:3] == 2'b10)
        else $error("sleep did not update flags");
    chk_wdclear_set: assert property (
        watchdog_clear_instruction && !sleep_instruction && !watchdog_timeout
        |=> status_value[4:3] == 2'b11) else $error("watchdog clear did not set flags");
    chk_ro_flags: assert property (
        reg_write && !any_event |=> $stable(status_value[4:3]))
        else $error("read-only flags changed by write");
    chk_result_valid: assert property (
        exec_result_valid == $past(exec_valid)) else $error("result valid misaligned");
    chk_sub_borrow: assert property (
        exec_valid && exec_op == core_status_pkg::OP_SUB
        |=> status_value[0] == ($past(exec_operand_a) >= $past(exec_operand_b))
            && exec_result == $past(exec_operand_a) - $past(exec_operand_b))
        else $error("subtract borrow wrong");
    chk_zero_flag: assert property (
        exec_valid && exec_op inside {core_status_pkg::OP_ADD, core_status_pkg::OP_XOR}
        |=> status_value[2] == (exec_result == '0)) else $error("zero flag wrong");
    chk_rotate_carry: assert property (
        exec_valid && exec_op == core_status_pkg::OP_ROTATE_LEFT |=> status_value[0] == a_top_q)
        else $error("rotate carry wrong");
    chk_clear_status: assert property (
        exec_valid && exec_op == core_status_pkg::OP_CLEAR && exec_dest_file
        && exec_dest_addr == 8'h03 |=> status_value[7:5] == 3'b000 && status_value[2])
        else $error("clear of status wrong");
    chk_read_idle: assert property (
        !reg_read |=> reg_rdata == 8'h00) else $error("read data not idle");

    cov_sub: cover property (exec_valid && exec_op == core_status_pkg::OP_SUB);
    cov_write_read: cover property (reg_write ##1 reg_read);
    cov_timeout: cover property (watchdog_timeout);
endmodule

// file: tb_core_status_flags.sv
`timescale 1ns/1ps
module tb_core_status_flags;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       exec_valid = 1'b0;
    logic [3:0] exec_op = 4'h0;
    logic [7:0] exec_operand_a = 8'h00;
    logic [7:0] exec_operand_b = 8'h00;
    logic [7:0] exec_dest_addr = 8'h03;
    logic       exec_dest_file = 1'b0;
    logic [6:0] direct_addr = 7'h00;
    logic       wdc = 1'b0;
    logic       slp = 1'b0;
    logic       wdt = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] exec_result;
    logic       exec_result_valid;
    logic [7:0] bank_address;
    logic [7:0] status_value;
    logic [7:0] st;
    logic [3:0] op;
    logic [2:0] exec_bit_index = 3'h0;
    logic [2:0] bit_idx = 3'h0;
    int         errors = 0;
    int         num_checks = 0;
    logic [3:0] ops [7] = '{core_status_pkg::OP_ADD, core_status_pkg::OP_SUB,
        core_status_pkg::OP_AND, core_status_pkg::OP_OR, core_status_pkg::OP_XOR,
        core_status_pkg::OP_ROTATE_LEFT, core_status_pkg::OP_ROTATE_RIGHT};
    logic [2:0] evs [6] = '{3'b100, 3'b010, 3'b100, 3'b001, 3'b010, 3'b100};

    always #4 ref_clk = ~ref_clk;

    core_status_flags dut (.ref_clk(ref_clk), .rst_n(rst_n), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_operand_a(exec_operand_a), .exec_operand_b(exec_operand_b),
        .exec_bit_index(exec_bit_index), .exec_dest_addr(exec_dest_addr),
        .exec_dest_file(exec_dest_file), .direct_addr(direct_addr),
        .watchdog_clear_instruction(wdc), .sleep_instruction(slp), .watchdog_timeout(wdt),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .exec_result(exec_result),
        .exec_result_valid(exec_result_valid), .bank_address(bank_address),
        .status_value(status_value));

    // ----------------------------------------
    // expectation and compare helpers
    // ----------------------------------------
    function automatic logic [7:0] model(input logic [3:0] o, input logic [7:0] a,
                                         input logic [7:0] b, input logic dst);
        logic       sub;
        logic       zf;
        logic       rot;
        logic [7:0] bx;
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] r;
        sub = (o == core_status_pkg::OP_SUB);
        zf = o inside {core_status_pkg::OP_ADD, core_status_pkg::OP_SUB,
                       core_status_pkg::OP_AND, core_status_pkg::OP_OR,
                       core_status_pkg::OP_XOR, core_status_pkg::OP_CLEAR};
        rot = (o == core_status_pkg::OP_ROTATE_LEFT) || (o == core_status_pkg::OP_ROTATE_RIGHT);
        bx = sub ? ~b : b;
        sum = {1'b0, a} + {1'b0, bx} + 9'(sub);
        nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + 5'(sub);
        r = a;
        case (o)
            core_status_pkg::OP_ADD, core_status_pkg::OP_SUB: begin
                r = sum[7:0];
                st[1:0] = {nib[4], sum[8]};
            end
            core_status_pkg::OP_AND: r = a & b;
            core_status_pkg::OP_OR: r = a | b;
            core_status_pkg::OP_XOR: r = a ^ b;
            core_status_pkg::OP_ROTATE_LEFT: begin
                r = {a[6:0], st[0]};
                st[0] = a[7];
            end
            core_status_pkg::OP_ROTATE_RIGHT: begin
                r = {st[0], a[7:1]};
                st[0] = a[0];
            end
            core_status_pkg::OP_CLEAR: r = 8'h00;
            core_status_pkg::OP_BIT_CLEAR: r[bit_idx] = 1'b0;
            core_status_pkg::OP_BIT_SET: r[bit_idx] = 1'b1;
            default: r = a;
        endcase
        if (zf) st[2] = (r == 8'h00);
        if (dst) st[7:5] = r[7:5];
        // instructions that leave the flags alone write the low bits as data
        if (dst && !zf && !rot) st[2:0] = r[2:0];
        return r;
    endfunction

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic verify;
        check8("status", st, status_value);
        check8("bank", {st[5], direct_addr}, bank_address);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        direct_addr <= 7'($urandom);
        @(posedge ref_clk);
        reg_write <= 1'b0;
        @(negedge ref_clk);
        if (a == 8'h03) st = (st & 8'h18) | (d & 8'hE7);
        verify();
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        check8("rdata", exp, reg_rdata);
    endtask

    task automatic ev(input logic [2:0] e);
        @(posedge ref_clk);
        {wdc, slp, wdt} <= e;
        @(posedge ref_clk);
        {wdc, slp, wdt} <= 3'b000;
        @(negedge ref_clk);
        if (e[0]) st[4] = 1'b0;
        else if (e[1]) st[4:3] = 2'b10;
        else st[4:3] = 2'b11;
        verify();
    endtask

    task automatic exe(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
                       input logic dst);
        logic [7:0] r;
        @(posedge ref_clk);
        exec_valid <= 1'b1;
        exec_op <= o;
        exec_operand_a <= a;
        exec_operand_b <= b;
        exec_dest_file <= dst;
        exec_bit_index <= bit_idx;
        @(posedge ref_clk);
        exec_valid <= 1'b0;
        @(negedge ref_clk);
        r = model(o, a, b, dst);
        check8("result", r, exec_result);
        check8("valid", 8'h01, {7'h00, exec_result_valid});
        verify();
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(74));
        st = 8'h18;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check8("reset", 8'h18, status_value);
        $display("test reset done");
        reg_wr(8'h03, 8'h00);
        ev(3'b001);
        reg_wr(8'h03, 8'h3F);
        reg_rd(8'h03, st);
        reg_wr(8'h04, 8'h00);
        reg_rd(8'h04, 8'h00);
        reg_wr(8'h03, 8'h00);
        $display("test bus done");
        foreach (evs[i]) ev(evs[i]);
        $display("test events done");
        exe(ops[1], 8'h05, 8'h05, 1'b0);
        exe(ops[1], 8'h00, 8'h01, 1'b0);
        exe(ops[1], 8'h10, 8'h01, 1'b0);
        exe(ops[0], 8'h0F, 8'h01, 1'b0);
        exe(ops[0], 8'hFF, 8'h01, 1'b0);
        exe(ops[5], 8'h80, 8'h00, 1'b0);
        exe(ops[6], 8'h01, 8'h00, 1'b0);
        repeat (80) begin
            op = ops[$urandom_range(6)];
            exe(op, 8'($urandom), 8'($urandom), 1'b0);
        end
        $display("test arithmetic done");
        reg_wr(8'h03, 8'h23);
        exe(core_status_pkg::OP_CLEAR, 8'h00, 8'h00, 1'b1);
        exe(ops[0], 8'hF0, 8'h30, 1'b1);
        exe(ops[1], 8'h30, 8'h10, 1'b1);
        exe(core_status_pkg::OP_NONE, 8'h01, 8'h00, 1'b1);
        bit_idx = 3'h2;
        exe(core_status_pkg::OP_BIT_SET, st, 8'h00, 1'b1);
        bit_idx = 3'h5;
        exe(core_status_pkg::OP_BIT_SET, st, 8'h00, 1'b1);
        bit_idx = 3'h2;
        exe(core_status_pkg::OP_BIT_CLEAR, st, 8'h00, 1'b1);
        reg_rd(8'h03, st);
        $display("test status destination done");
        print_verdict();
    end

    initial begin
        #200000;
        errors++;
        print_verdict();
    end
endmodule

bind core_status_flags core_status_flags_checker #(.WIDTH(WIDTH)) chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_operand_a(exec_operand_a), .exec_operand_b(exec_operand_b),
    .exec_dest_addr(exec_dest_addr), .exec_dest_file(exec_dest_file),
    .direct_addr(direct_addr), .watchdog_clear_instruction(watchdog_clear_instruction),
    .sleep_instruction(sleep_instruction), .watchdog_timeout(watchdog_timeout),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .exec_result(exec_result), .exec_result_valid(exec_result_valid),
    .bank_address(bank_address), .status_value(status_value));
